// ===== rtl/bfc_pkg.sv
// =============================================================
// Register map and field layout of the framing and driver control block.
package bfc_pkg;
   localparam logic [7:0] OFS_CRC_HIGH      = 8'h0E;
   localparam logic [7:0] OFS_BIT_FRAMING   = 8'h0F;
   localparam logic [7:0] OFS_DRIVER_CTRL   = 8'h11;
   localparam logic [7:0] RST_BIT_FRAMING   = 8'h00;
   localparam logic [7:0] RST_DRIVER_CTRL   = 8'h58;
   localparam int         RX_OFFSET_LSB     = 4;
   localparam int         FINAL_BITS_LSB    = 0;
   localparam int         MOD_SEL_LSB       = 5;
   localparam int         B_INVERT_BIT      = 3;
   localparam int         B_CW_BIT          = 2;
   localparam int         B_RF_EN_BIT       = 1;
   localparam int         A_RF_EN_BIT       = 0;
   localparam logic [7:0] FRAMING_WR_MASK   = 8'h77;
   typedef enum logic [1:0] {
      BFC_MOD_LOW,
      BFC_MOD_HIGH,
      BFC_MOD_ENCODER,
      BFC_MOD_EXTERNAL
   } bfc_mod_sel_t;
endpackage

// ===== rtl/bfc_top.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: CRC high register returns engine result high byte.
// RULE2: High byte undefined for 8-bit CRC.
// RULE3: Offset field bits 6:4 places first received bit.
// RULE4: Later bits go upward, wrapping to next byte.
// RULE5: Offset 000 uses bits 0,1; 001 bits 1,2.
// RULE6: Offset 111 uses bit 7, then next byte.
// RULE7: Offset field clears after reception completes.
// RULE8: Bits 2:0 give final byte bits; 000 means eight.
// RULE9: Final bit count clears after transmission ends.
// RULE10: Bits 6:5 pick modulator input source.
// RULE11: Invert bit makes output B inverted carrier.
// RULE12: Continuous-wave bit keeps output B unmodulated.
// RULE13: RF enable B gates modulated carrier, else constant.
// RULE14: RF enable A gates modulated carrier, else constant.
// RULE15: Software keeps driver control bits 7 and 4.
module bfc_top
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [15:0] crc_result,
   input  wire logic       crc_done_flag,
   input  wire logic       rx_done,
   input  wire logic       tx_done,
   input  wire logic       rx_bit_valid,
   input  wire logic       rx_bit,
   input  wire logic       rx_start,
   output logic      [7:0] rx_byte,
   output logic            rx_byte_valid,
   output logic      [2:0] final_byte_bit_count,
   input  wire logic       carrier,
   input  wire logic       encoder_out,
   input  wire logic       external_modulation_input,
   output logic            antenna_output_a,
   output logic            antenna_output_b
);

   // ==========================================================
   // Register storage.
   logic [7:0] framing_reg;
   logic [7:0] framing_next;
   logic [7:0] driver_reg;
   logic [7:0] driver_next;
   logic [7:0] crc_high_reg;

   // Address decode shared by the write strobes and the read multiplexer:
   // bit 0 hits the CRC high byte, bit 1 framing, bit 2 driver control.
   function automatic logic [2:0] decode_addr(input logic [7:0] addr);
      decode_addr[0] = (addr == bfc_pkg::OFS_CRC_HIGH);
      decode_addr[1] = (addr == bfc_pkg::OFS_BIT_FRAMING);
      decode_addr[2] = (addr == bfc_pkg::OFS_DRIVER_CTRL);
   endfunction

   // Writes to the read-only CRC byte or to unmapped addresses fall away.
   wire [2:0] addr_hit   = decode_addr(reg_addr);
   wire       wr_framing = reg_wr && addr_hit[1];
   wire       wr_driver  = reg_wr && addr_hit[2];

   // A completed frame clears its field; a same-cycle host write loses.
   // Reserved bits 7 and 3 are masked on write, so they always read zero.
   always_comb
   begin
      framing_next = framing_reg;
      if (wr_framing)
         framing_next = reg_wdata & bfc_pkg::FRAMING_WR_MASK;
      if (rx_done)
         framing_next[bfc_pkg::RX_OFFSET_LSB +: 3] = 3'h0; // RULE7
      if (tx_done)
         framing_next[bfc_pkg::FINAL_BITS_LSB +: 3] = 3'h0; // RULE9
   end

   // Driver control stores all bits; software keeps bits 7 and 4 as reset.
   // No frame event touches this register, only host writes do.
   assign driver_next = wr_driver ? reg_wdata : driver_reg; // RULE15

   // Register update; the asynchronous reset restores the reset values.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         framing_reg <= bfc_pkg::RST_BIT_FRAMING;
         driver_reg  <= bfc_pkg::RST_DRIVER_CTRL;
      end
      else
      begin
         framing_reg <= framing_next;
         driver_reg  <= driver_next;
      end
   end

   // ==========================================================
   // CRC high byte capture; content only meaningful while done flag is set,
   // and meaningless for an 8-bit CRC, where the engine high byte is passed as is.
   // Once the flag drops the captured byte is frozen, so later reads keep it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         crc_high_reg <= 8'h00;
      else if (crc_done_flag)
         crc_high_reg <= crc_result[15:8]; // RULE1 RULE2
   end

   // ==========================================================
   // Read multiplexer; unmapped addresses read zero.
   wire [7:0] rd_mux = addr_hit[0] ? crc_high_reg :
                       addr_hit[1] ? framing_reg  :
                       addr_hit[2] ? driver_reg   : 8'h00;

   // Read data is registered and stands until the next read strobe.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rd_mux;
   end

   // ==========================================================
   // Receive bit packer: first bit lands at the offset, later bits climb.
   // The bit position wraps from 7 to 0 by itself, so a byte that fills
   // is handed over and the next bit starts the following byte at bit 0.
   // A partial byte at the end of a frame is not handed over here.
   logic [2:0] pos_reg;
   logic [7:0] acc_reg;
   wire  [2:0] rx_offset = framing_reg[bfc_pkg::RX_OFFSET_LSB +: 3];
   wire  [7:0] bit_mask  = 8'h01 << pos_reg;
   wire  [7:0] acc_set   = rx_bit ? (acc_reg | bit_mask) : acc_reg;
   wire        byte_full = (pos_reg == 3'h7);

   // A start pulse reloads the offset and clears the partial byte.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pos_reg       <= 3'h0;
         acc_reg       <= 8'h00;
         rx_byte       <= 8'h00;
         rx_byte_valid <= 1'b0;
      end
      else
      begin
         rx_byte_valid <= 1'b0;
         if (rx_start)
         begin
            pos_reg <= rx_offset; // RULE3 RULE5 RULE6
            acc_reg <= 8'h00;
         end
         else if (rx_bit_valid)
         begin
            pos_reg <= pos_reg + 3'h1; // RULE4
            if (byte_full)
            begin
               rx_byte       <= acc_set; // RULE6
               rx_byte_valid <= 1'b1;
               acc_reg       <= 8'h00;
            end
            else
               acc_reg <= acc_set;
         end
      end
   end

   // Final byte bit count to the transmitter; 000 means all eight bits.
   // It is taken from the next value, so the transmitter sees a fresh count
   // in the same cycle in which the register shows it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         final_byte_bit_count <= 3'h0;
      else
         final_byte_bit_count <= framing_next[bfc_pkg::FINAL_BITS_LSB +: 3]; // RULE8
   end

   // ==========================================================
   // Modulator source and antenna drive.
   // The select field maps straight onto the source enum.
   bfc_pkg::bfc_mod_sel_t mod_sel;
   logic                  mod_in;
   assign mod_sel = bfc_pkg::bfc_mod_sel_t'(driver_reg[bfc_pkg::MOD_SEL_LSB +: 2]);

   // Source selection; every select value has a branch of its own.
   always_comb
   begin
      case (mod_sel)
         bfc_pkg::BFC_MOD_LOW:      mod_in = 1'b0; // RULE10
         bfc_pkg::BFC_MOD_HIGH:     mod_in = 1'b1;
         bfc_pkg::BFC_MOD_ENCODER:  mod_in = encoder_out;
         bfc_pkg::BFC_MOD_EXTERNAL: mod_in = external_modulation_input;
         default:                   mod_in = 1'b0;
      endcase
   end

   // Modulation high gates the carrier off (pulse modulation).
   // Output B: continuous wave bypasses the modulator and invert flips the wave.
   // A cleared enable holds either pin low.
   wire carrier_mod = carrier & ~mod_in;
   wire b_base      = driver_reg[bfc_pkg::B_CW_BIT] ? carrier : carrier_mod; // RULE12
   wire b_wave      = driver_reg[bfc_pkg::B_INVERT_BIT] ? ~b_base : b_base; // RULE11
   wire a_drive     = driver_reg[bfc_pkg::A_RF_EN_BIT] ? carrier_mod : 1'b0; // RULE14
   wire b_drive     = driver_reg[bfc_pkg::B_RF_EN_BIT] ? b_wave : 1'b0; // RULE13

   // Both pins are registered, so each lags its inputs by one clock.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         antenna_output_a <= 1'b0;
         antenna_output_b <= 1'b0;
      end
      else
      begin
         antenna_output_a <= a_drive;
         antenna_output_b <= b_drive;
      end
   end

endmodule

// ===== sim/bfc_top_assertions.sv
`timescale 1ns/10ps
// ==========
// Port checks for the framing and driver control block.
module bfc_top_chk
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       rx_done,
   input wire logic       tx_done,
   input wire logic [2:0] final_byte_bit_count,
   input wire logic       carrier,
   input wire logic       encoder_out,
   input wire logic       external_modulation_input,
   input wire logic       antenna_output_a,
   input wire logic       antenna_output_b
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Write strobes of the two writable registers; frame clears win over a write.
   wire fr_wr = reg_wr && reg_addr == 8'h0F && !tx_done && !rx_done;
   wire dc_wr = reg_wr && reg_addr == 8'h11;
   // A framing write followed at once by a framing read.
   sequence s_wr_rd;
      fr_wr ##1 reg_rd && reg_addr == 8'h0F;
   endsequence
   a_frame_read: assert property (s_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 8'h77))
      else $error("framing read-back wrong");
   a_count_write: assert property (fr_wr |=> final_byte_bit_count == $past(reg_wdata[2:0]))
      else $error("bit count not loaded");
   a_count_clear: assert property (tx_done |=> final_byte_bit_count == 3'h0)
      else $error("bit count not cleared");
   a_drive_a_off: assert property (dc_wr && !reg_wdata[0] |=> ##1 !antenna_output_a)
      else $error("output a not constant");
   a_drive_b_off: assert property (dc_wr && !reg_wdata[1] |=> ##1 !antenna_output_b)
      else $error("output b not constant");
   a_b_inv_cw: assert property (dc_wr && reg_wdata[3:1] == 3'h7 |=> ##1 antenna_output_b == !$past(carrier))
      else $error("output b not inverted carrier");
   a_mod_low: assert property (dc_wr && reg_wdata[6:0] == 7'h11 |=> ##1 antenna_output_a == $past(carrier))
      else $error("low source modulates");
   a_mod_high: assert property (dc_wr && reg_wdata[6:0] == 7'h31 |=> ##1 !antenna_output_a)
      else $error("high source passes carrier");
   a_mod_encoder: assert property (dc_wr && reg_wdata[6:0] == 7'h51 |=>
      ##1 antenna_output_a == ($past(carrier) && !$past(encoder_out)))
      else $error("encoder source not applied");
   a_mod_external: assert property (dc_wr && reg_wdata[6:0] == 7'h71 |=>
      ##1 antenna_output_a == ($past(carrier) && !$past(external_modulation_input)))
      else $error("external source not applied");
endmodule
bind bfc_top bfc_top_chk bfc_top_chk_inst
(
   .clk                       (clk),
   .rst_n                     (rst_n),
   .reg_addr                  (reg_addr),
   .reg_wr                    (reg_wr),
   .reg_rd                    (reg_rd),
   .reg_wdata                 (reg_wdata),
   .reg_rdata                 (reg_rdata),
   .rx_done                   (rx_done),
   .tx_done                   (tx_done),
   .final_byte_bit_count      (final_byte_bit_count),
   .carrier                   (carrier),
   .encoder_out               (encoder_out),
   .external_modulation_input (external_modulation_input),
   .antenna_output_a          (antenna_output_a),
   .antenna_output_b          (antenna_output_b)
);

// ===== sim/bfc_card_model.sv
`timescale 1ns/10ps
// ==========
// Field side: the carrier reaching the drivers and the card's modulation pin.
module bfc_card_model
(
   input  wire logic clk,
   output logic      carrier,
   output logic      external_modulation_input
);
   logic [7:0] pat_reg = 8'hA5;
   // A shifting pattern keeps both lines changing irregularly.
   always @(posedge clk)
      pat_reg <= {pat_reg[6:0], pat_reg[7] ^ pat_reg[5]};
   assign carrier = pat_reg[0];
   assign external_modulation_input = pat_reg[3];
endmodule

// ===== sim/bfc_top_bench.sv
`timescale 1ns/10ps
// ==========
// Self-checking bench for the framing and driver control block.
module bfc_top_bench;
   logic        clk = '0, rst_n = '0, reg_wr = '0, reg_rd = '0, crc_done_flag = '0, rx_done = '0, rdp = '0;
   logic        tx_done = '0, rx_bit_valid = '0, rx_bit = '0, rx_start = '0, encoder_out = '0;
   logic        rx_byte_valid, carrier, external_modulation_input, antenna_output_a, antenna_output_b;
   logic [7:0]  reg_addr = '0, reg_wdata = '0, reg_rdata, rx_byte, exp_q[$], byte_q[$];
   logic [15:0] crc_result = '0, w;
   logic [2:0]  final_byte_bit_count;
   logic [23:0] v;
   logic [31:0] seed = 32'h0000EB2D;
   int          miscompares = 0, tests_run = 0;
   bfc_top bfc_top_inst (.*);
   bfc_card_model bfc_card_model_inst (.*);
   initial forever #2 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
   endtask
   task automatic report(input string nm, input logic [7:0] e, seen);
      tests_run++;
      if (e !== seen)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, seen);
      end
   endtask
   // Read answers, each against the oldest read note.
   task automatic chk_rd(input logic [7:0] seen);
      if (exp_q.size() == 0)
      begin
         miscompares++;
         $display("BAD rdata expected none seen %h", seen);
      end
      else
         report("rdata", exp_q.pop_front(), seen);
   endtask
   // Assembled bytes, each against the oldest byte note.
   task automatic chk_byte(input logic [7:0] seen);
      if (byte_q.size() == 0)
      begin
         miscompares++;
         $display("BAD rx_byte expected none seen %h", seen);
      end
      else
         report("rx_byte", byte_q.pop_front(), seen);
   endtask
   task automatic wrap_up();
      if (miscompares == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic drain();
      for (int n = 0; n < 50 && (exp_q.size() > 0 || byte_q.size() > 0); n++)
         @(posedge clk);
      if (exp_q.size() > 0 || byte_q.size() > 0)
      begin
         miscompares++;
         wrap_up();
      end
   endtask
   // Read answers and assembled bytes are matched against the oldest note.
   always @(posedge clk)
   begin
      rdp <= reg_rd;
      encoder_out <= seed[9];
   end
   always @(negedge clk)
   begin
      if (rdp)
         chk_rd(reg_rdata);
      if (rx_byte_valid)
         chk_byte(rx_byte);
   end
   // Main sequence: reset values, CRC capture, frame clears, bit placement, drivers.
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      rd(8'h0F, 8'h00);
      cyc(1);
      rd(8'h10, 8'h00);
      cyc(1);
      rd(8'h11, 8'h58);
      w = 16'(rnd());
      crc_result <= w;
      crc_done_flag <= 1'h1;
      cyc(1);
      crc_done_flag <= 1'h0;
      crc_result <= ~w;
      rd(8'h0E, w[15:8]);
      wr(8'h0F, w[7:0]);
      rd(8'h0F, w[7:0] & 8'h77);
      tx_done <= 1'h1;
      cyc(1);
      tx_done <= 1'h0;
      rd(8'h0F, w[7:0] & 8'h70);
      for (int o = 0; o < 8; o++)
      begin
         w = 16'(rnd());
         v = 24'(w) << o;
         wr(8'h0F, 8'(o << 4) | 8'h05);
         rx_start <= 1'h1;
         cyc(1);
         rx_start <= 1'h0;
         byte_q.push_back(v[7:0]);
         byte_q.push_back(v[15:8]);
         for (int k = 0; k < 16 - o; k++)
         begin
            rx_bit_valid <= 1'h1;
            rx_bit <= w[k];
            cyc(1);
            if (rnd() % 3 == 0)
            begin
               rx_bit_valid <= 1'h0;
               cyc(1);
            end
         end
         rx_bit_valid <= 1'h0;
         rx_done <= 1'h1;
         cyc(1);
         rx_done <= 1'h0;
         rd(8'h0F, 8'h05);
         drain();
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h11, 8'(i << 5) | 8'h1E);
         cyc(3);
         wr(8'h11, 8'(i << 5) | 8'h11);
         rd(8'h11, 8'(i << 5) | 8'h11);
         cyc(3);
      end
      drain();
      // A second reset in mid-run brings back the reset values.
      rst_n <= 1'h0;
      cyc(2);
      rst_n <= 1'h1;
      rd(8'h11, 8'h58);
      cyc(1);
      rd(8'h0F, 8'h00);
      drain();
      wrap_up();
   end
endmodule
